// file: rtl/code_defs_pkg.sv
// constants, types and the oscillator tick divider for the code encoder.
// assumes a single synchronous clock and an active-low synchronous reset.

`timescale 1ns/1ps
`default_nettype none

package code_defs_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned OSC_FREQ_HZ = 76_000;
  // clock cycles per oscillator period, rounded down
  localparam int unsigned OSC_DIV     = CLK_FREQ_HZ / OSC_FREQ_HZ;

  localparam logic [6:0] PULSE_LEN   = 7'd16;
  localparam logic [6:0] SHORT_HIGH  = 7'd4;
  localparam logic [6:0] LONG_HIGH   = 7'd12;
  localparam logic [6:0] BIT_LEN     = 7'd32;
  localparam int unsigned SYNC_BITS  = 4;
  localparam logic [7:0] SYNC_LEN    = 8'(BIT_LEN * SYNC_BITS);
  localparam logic [7:0] SYNC_HIGH   = 8'(BIT_LEN / 8);

  // ********************************************************
  // word and frame layout
  // ********************************************************
  localparam int unsigned GROUP_PINS  = 6;
  localparam logic [3:0]  WORD_BITS   = 4'd12;
  localparam logic [1:0]  LAST_WORD   = 2'd3;  // four words a frame

  // ********************************************************
  // types
  // ********************************************************
  // a three-level pin: driven flag and driven level
  typedef struct packed {
    logic driven;
    logic level;
  } code_pin_s;

  typedef enum logic [1:0] {
    SYM_ZERO,
    SYM_ONE,
    SYM_FLOAT
  } sym_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CODE,
    ST_SYNC
  } enc_state_e;

endpackage : code_defs_pkg

// ********************************************************
// oscillator tick: one-cycle pulse every DIV clocks
// ********************************************************
module osc_tick_gen #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic      tick_q
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        tick_d;

  // count down to zero then reload, free running
  always_comb begin
    tick_d = (cnt_q == 16'h0000);
    if (tick_d) begin
      cnt_d = 16'(DIV - 1);
    end else begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule : osc_tick_gen

`default_nettype wire

// file: rtl/code_encoder.sv
// serial tri-state remote-control code encoder.
// assumes code pins and gate are synchronous to clk; the oscillator
// period is a fixed division of clk.

`timescale 1ns/1ps
`default_nettype none

module tristate_remote_code_encoder
  import code_defs_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 transmit_gate_n,
  input  wire logic                 ir_mode,
  input  wire code_defs_pkg::code_pin_s [5:0] pure_code_inputs,
  input  wire code_defs_pkg::code_pin_s [5:0] shared_code_inputs,
  output logic                      coded_out_q,
  output logic                      frame_active_q
);
  import code_defs_pkg::*;

  // ********************************************************
  // oscillator
  // ********************************************************
  logic osc_tick;

  osc_tick_gen #(
    .DIV (OSC_DIV)
  ) u_osc (
    .clk    (clk),
    .rst_b  (rst_b),
    .tick_q (osc_tick)
  );

  // ********************************************************
  // pin selection and symbol decode
  // ********************************************************
  enc_state_e state_q;
  enc_state_e state_d;
  logic [7:0] phase_q;
  logic [7:0] phase_d;
  logic [3:0] bit_idx_q;
  logic [3:0] bit_idx_d;
  logic [1:0] word_idx_q;
  logic [1:0] word_idx_d;
  sym_e       sym_q;
  sym_e       sym_d;
  code_pin_s  cur_pin;
  sym_e       cur_sym;
  logic [3:0] next_idx;

  // pins in order: pure group first, shared group after
  function automatic code_pin_s pick_pin(input logic [3:0] idx,
                                         input code_pin_s [5:0] lo,
                                         input code_pin_s [5:0] hi);
    code_pin_s p;
    p = '0;
    if (idx < 4'(GROUP_PINS)) begin
      p = lo[idx[2:0]];
    end else if (idx < WORD_BITS) begin
      p = hi[3'(idx - 4'(GROUP_PINS))];
    end
    return p;
  endfunction : pick_pin

  // next position is sampled at its own start so late pin changes count
  always_comb begin
    next_idx = (state_q == ST_CODE) ? bit_idx_q + 4'h1 : 4'h0;
    cur_pin  = pick_pin(next_idx, pure_code_inputs,
                        shared_code_inputs);
    if (!cur_pin.driven) begin
      cur_sym = SYM_FLOAT;
    end else if (cur_pin.level) begin
      cur_sym = SYM_ONE;
    end else begin
      cur_sym = SYM_ZERO;
    end
  end

  // ********************************************************
  // sequencer: bit, word and frame counters
  // ********************************************************
  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    bit_idx_d  = bit_idx_q;
    word_idx_d = word_idx_q;
    sym_d      = sym_q;
    if (osc_tick) begin
      case (state_q)
        ST_IDLE: begin
          if (!transmit_gate_n) begin
            state_d    = ST_CODE;
            phase_d    = 8'h00;
            bit_idx_d  = 4'h0;
            word_idx_d = 2'd0;
            sym_d      = cur_sym;
          end
        end
        ST_CODE: begin
          if (phase_q == 8'(BIT_LEN - 7'd1)) begin
            phase_d = 8'h00;
            if (bit_idx_q == WORD_BITS - 4'h1) begin
              state_d = ST_SYNC;
            end else begin
              bit_idx_d = bit_idx_q + 4'h1;
              sym_d     = cur_sym;
            end
          end else begin
            phase_d = phase_q + 8'h01;
          end
        end
        ST_SYNC: begin
          if (phase_q == SYNC_LEN - 8'h01) begin
            phase_d   = 8'h00;
            bit_idx_d = 4'h0;
            sym_d     = cur_sym;
            if (word_idx_q != LAST_WORD) begin
              state_d    = ST_CODE;
              word_idx_d = word_idx_q + 2'd1;
            end else if (!transmit_gate_n) begin
              state_d    = ST_CODE;
              word_idx_d = 2'd0;
            end else begin
              // gate released: frame done, go quiet
              state_d    = ST_IDLE;
              word_idx_d = 2'd0;
            end
          end else begin
            phase_d = phase_q + 8'h01;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      phase_q    <= 8'h00;
      bit_idx_q  <= 4'h0;
      word_idx_q <= 2'd0;
      sym_q      <= SYM_ZERO;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      bit_idx_q  <= bit_idx_d;
      word_idx_q <= word_idx_d;
      sym_q      <= sym_d;
    end
  end

  // ********************************************************
  // waveform shaping and infrared carrier
  // ********************************************************
  logic       carrier_q;
  logic       carrier_d;
  logic       high_d;
  logic       out_d;
  logic       long_cyc;
  logic [6:0] in_cycle;
  logic       second_cyc;

  // carrier flips every oscillator period: half rate, even duty
  always_comb begin
    carrier_d = carrier_q;
    if (state_d == ST_IDLE) begin
      // parked low so the first toggle of a frame opens high
      carrier_d = 1'b0;
    end else if (osc_tick) begin
      carrier_d = ~carrier_q;
    end
  end

  // first cycle long only for one; second long for one or floating
  always_comb begin
    second_cyc = (phase_d[6:0] >= PULSE_LEN);
    in_cycle   = second_cyc ? phase_d[6:0] - PULSE_LEN : phase_d[6:0];
    if (second_cyc) begin
      long_cyc = (sym_d != SYM_ZERO);
    end else begin
      long_cyc = (sym_d == SYM_ONE);
    end
    high_d = 1'b0;
    case (state_d)
      ST_CODE: begin
        high_d = long_cyc ? (in_cycle < LONG_HIGH)
                          : (in_cycle < SHORT_HIGH);
      end
      ST_SYNC: begin
        high_d = (phase_d < SYNC_HIGH);
      end
      default: begin
        high_d = 1'b0;
      end
    endcase
    // infrared only chops highs; word and frame timing untouched
    out_d = high_d & (~ir_mode | carrier_d);
  end

  // outputs registered from next-state values: waveform in step with the counters, no lag
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      carrier_q      <= 1'b0;
      coded_out_q    <= 1'b0;
      frame_active_q <= 1'b0;
    end else begin
      carrier_q      <= carrier_d;
      coded_out_q    <= out_d;
      frame_active_q <= (state_d != ST_IDLE);
    end
  end

endmodule : tristate_remote_code_encoder

`default_nettype wire

// file: verif/code_encoder_assertions.sv
// port assertions for the tri-state code encoder
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
`default_nettype none
module code_encoder_checker
  import code_defs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic transmit_gate_n,
  input  wire logic ir_mode,
  input  wire logic coded_out_q,
  input  wire logic frame_active_q
);
  localparam int A   = OSC_DIV;
  localparam int LAT = A + 1;
  int hi_q;
  int lo_q;
  // ********************************************************
  // run lengths of the line, counted in clocks
  // ********************************************************
  always_ff @(posedge clk) begin
    hi_q <= (rst_b && coded_out_q) ? hi_q + 1 : 0;
    lo_q <= (rst_b && !coded_out_q) ? lo_q + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_IDLE_LOW: assert property (!frame_active_q |-> !coded_out_q)
    else $error("line high outside a frame");
  AST_GATE_START: assert property ($fell(transmit_gate_n) &&
    !frame_active_q |-> ##[1:LAT] frame_active_q) else $error("no start");
  AST_START_CAUSE: assert property ($rose(frame_active_q)
    |-> !$past(transmit_gate_n)) else $error("start without gate");
  AST_START_HIGH: assert property ($rose(frame_active_q)
    |-> coded_out_q) else $error("frame did not open high");
  AST_HIGH_SHAPE: assert property ($fell(coded_out_q) && !ir_mode
    |-> hi_q == 4 * A || hi_q == 12 * A) else $error("bad high width");
  AST_HIGH_BOUND: assert property (coded_out_q && !ir_mode
    |-> hi_q < 12 * A) else $error("high too long");
  AST_IR_CARRIER: assert property ($fell(coded_out_q) && ir_mode
    |-> hi_q == A) else $error("carrier half period wrong");
  AST_LOW_BOUND: assert property (frame_active_q && !coded_out_q
    && !ir_mode |-> lo_q < 124 * A) else $error("low too long");
  // a release late in a closing sync low may see the frame end at once
  AST_FRAME_HOLD: assert property (frame_active_q &&
    lo_q < 100 * A && $rose(transmit_gate_n) |=> frame_active_q [*8])
    else $error("cut short");
endmodule : code_encoder_checker
`default_nettype wire

// file: verif/code_rx_model.sv
// receiver model: decodes pulse cycles of the coded line
// assumes highs and lows are whole oscillator periods of clk
`timescale 1ns/1ps
`default_nettype none
module code_rx_model
  import code_defs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic line,
  output logic      sym_valid_q,
  output sym_e      sym_q,
  output logic      sync_q
);
  localparam int   A   = OSC_DIV;
  localparam sym_e BAD = sym_e'(2'd3);
  int   hi_q;
  int   lo_q;
  logic prev_q;
  logic half_q;
  logic long_q;
  // classify a pulse cycle at the rise that ends it
  always_ff @(posedge clk) begin
    sym_valid_q <= 1'b0;
    sync_q      <= 1'b0;
    prev_q      <= line;
    if (!rst_b) begin
      hi_q   <= 0;
      half_q <= 1'b0;
    end else if (line && !prev_q) begin
      hi_q        <= 1;
      lo_q        <= 0;
      half_q      <= (hi_q > 0) && !half_q;
      long_q      <= hi_q == 12 * A;
      sym_valid_q <= half_q;
      // widths counted in whole clocks, far finer than a decoder needs
      if (lo_q + hi_q != 16 * A) sym_q <= BAD;
      else if (hi_q == 4 * A) sym_q <= long_q ? BAD : SYM_ZERO;
      else sym_q <= long_q ? SYM_ONE : SYM_FLOAT;
    end else if (line) begin
      hi_q <= hi_q + 1;
    end else begin
      lo_q <= lo_q + 1;
      // a long low after a short high marks the sync bit
      if (lo_q == 20 * A && hi_q == 4 * A) begin
        sync_q <= 1'b1;
        hi_q   <= 0;
        half_q <= 1'b0;
      end
    end
  end
endmodule : code_rx_model
`default_nettype wire

// file: verif/tristate_remote_code_encoder_tb.sv
// self-checking bench for the tri-state code encoder
// assumes the package divider and the receiver model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tristate_remote_code_encoder_tb;
  import code_defs_pkg::*;
  typedef struct packed { code_pin_s pin; sym_e sym; } row_s;
  localparam int   A       = OSC_DIV;
  localparam row_s ROWS[3] = '{'{2'b10, SYM_ZERO}, '{2'b11, SYM_ONE},
                               '{2'b00, SYM_FLOAT}};
  logic             clk = 0, rst_b = 0, transmit_gate_n = 1, ir_mode = 0;
  logic             coded_out_q, frame_active_q, sym_valid_q, sync_q;
  logic             was_hi;
  code_pin_s [11:0] pins;
  sym_e             sym_q;
  sym_e             exp_sym[12];
  int               num_errors = 0, num_checks = 0, k, n;
  always #50 clk = ~clk;
  tristate_remote_code_encoder DUT (.clk(clk), .rst_b(rst_b),
    .transmit_gate_n(transmit_gate_n), .ir_mode(ir_mode),
    .pure_code_inputs(pins[5:0]), .shared_code_inputs(pins[11:6]),
    .coded_out_q(coded_out_q), .frame_active_q(frame_active_q));
  code_rx_model rx (.clk(clk), .rst_b(rst_b), .line(coded_out_q),
    .sym_valid_q(sym_valid_q), .sym_q(sym_q), .sync_q(sync_q));
  // inputs move a fixed 5 ns after each rising edge
  task tick();
    @(posedge clk);
    #5;
  endtask : tick
  task wait_frame();
    for (k = 0; k < 2 * A && frame_active_q !== 1'b1; k++) tick();
  endtask : wait_frame
  task print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // ********************************************************
  // watchdog, about 80k clocks
  // ********************************************************
  initial begin
    #8_000_000;
    num_errors++;
    print_verdict();
  end
  // ********************************************************
  // main sequence: one RF word, then a reset into IR mode
  // ********************************************************
  initial begin
    for (int i = 0; i < 12; i++) begin
      pins[i]    = ROWS[i % 3].pin;
      exp_sym[i] = ROWS[i % 3].sym;
    end
    repeat (4) tick();
    rst_b = 1;
    `CHK("idle line", 1'b0, coded_out_q)
    transmit_gate_n = 0;
    wait_frame();
    `CHK("frame start", 1'b1, frame_active_q)
    `CHK("first high", 1'b1, coded_out_q)
    // release mid-frame and alter the last pin before it is sent
    transmit_gate_n = 1;
    pins[11]    = ROWS[1].pin;
    exp_sym[11] = SYM_ONE;
    for (int i = 0; i < 12; i++) begin
      tick();
      for (k = 0; k < 40 * A && sym_valid_q !== 1'b1; k++) tick();
      `CHK("symbol", exp_sym[i], sym_q)
    end
    for (k = 0; k < 30 * A && sync_q !== 1'b1; k++) tick();
    `CHK("sync", 1'b1, sync_q)
    `CHK("frame held", 1'b1, frame_active_q)
    // second reset mid-frame, all zero bits, carrier on
    rst_b           = 0;
    ir_mode         = 1;
    transmit_gate_n = 0;
    pins            = {12{ROWS[0].pin}};
    repeat (4) tick();
    `CHK("reset line", 1'b0, frame_active_q)
    rst_b = 1;
    wait_frame();
    `CHK("ir first high", 1'b1, coded_out_q)
    n      = 0;
    was_hi = 1'b0;
    // a zero bit is two short highs, each two carrier pulses
    repeat (32 * A) begin
      n += (coded_out_q === 1'b1 && !was_hi) ? 1 : 0;
      was_hi = coded_out_q;
      tick();
    end
    `CHK("carrier pulses", 4, n)
    print_verdict();
  end
endmodule : tristate_remote_code_encoder_tb
bind tristate_remote_code_encoder code_encoder_checker chk (.clk(clk),
  .rst_b(rst_b), .transmit_gate_n(transmit_gate_n), .ir_mode(ir_mode),
  .coded_out_q(coded_out_q), .frame_active_q(frame_active_q));
`default_nettype wire
